// ==== hw/cid_exec.sv ====
// Purpose: Executes compare, inc, dec, interrupt enable/disable and idle
// Assumes: APB3 slave, ref_clk 250 MHz, irqReq pins asynchronous
// Notes:   Register file, flags and system_mode_reg live in this block
//
// Summary of operation
// - Compare subtracts source from destination; difference only updates flags.
// - Compare sets carry on borrow and sign on negative difference.
// - Compare leaves both operands unchanged in storage.
// - Compare overflow on opposite signs with result sign equal source; D, H kept.
// - Decrement subtracts one and writes back to the same location.
// - Decrement sets zero and sign from result; C, D, H kept.
// - Decrement overflow only when 80H becomes 7FH.
// - Increment adds one and writes back to the same location.
// - Increment sets zero and sign from result; C, D, H kept.
// - Increment overflow only when 7FH becomes 80H.
// - Interrupt disable clears system mode bit 2 only.
// - While disabled, requests still set pending bits but are not serviced.
// - Interrupt disable is opcode 8F taking 4 cycles.
// - Interrupt enable sets system mode bit 2.
// - Pending interrupts are serviced once re-enabled.
// - Idle gates the CPU clock while the oscillator runs.
// - Idle ends on an interrupt request or reset, clock restarts.
`include "cid_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cid_exec #(
    parameter int NREG = 16,
    parameter int AW   = 4,
    parameter int NIRQ = 8
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Interrupt request pins
    input  wire logic [NIRQ-1:0]   irqReq,
    // CPU side
    output logic                   cpuClkEn,
    output logic                   serviceReq
);
    import cid_pkg::*;

    typedef struct packed {
        logic [NIRQ-1:0]       irqMeta;
        logic [NIRQ-1:0]       irqSync;
        logic [NIRQ-1:0]       irqLast;
        cid_state_t            st;
        logic [2:0]            cycLeft;
        logic [23:0]           cmd;
        logic                  badOp;
        logic [7:0]            flags;
        logic [7:0]            system_mode_reg;
        logic [NIRQ-1:0]       pend;
        logic [NREG-1:0][7:0]  regs;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
        logic                  cpuClkEn;
        logic                  serviceReq;
    } cid_core_t;

    cid_core_t             s;
    cid_core_t             next_s;
    logic [1:0]            rstPipe;
    logic                  rstn;
    logic [7:0]            op;
    logic [7:0]            b1;
    logic [7:0]            b2;
    logic [AW-1:0]         dstA;
    logic [7:0]            dstVal;
    logic [7:0]            srcVal;
    cid_alu_op_t           aluOp;
    logic [7:0]            aluRes;
    logic [7:0]            aluFlags;
    logic [NIRQ-1:0]       irqEdge;
    logic                  access;
    logic [11:0]           regOff;
    logic                  isReg;
    logic [AW-1:0]         regIdx;

    // Register address from an 8-bit operand
    function automatic logic [AW-1:0] idx(input logic [7:0] a);
        return a[AW-1:0];
    endfunction

    // Cycles per opcode, zero when not handled here
    function automatic logic [2:0] cyclesOf(input logic [7:0] o);
        logic [2:0] c;
        c = 3'h0;
        unique case (o)
            `CID_OP_CP_RR, `CID_OP_DEC_R, `CID_OP_DEC_IR,
            `CID_OP_INC_R, `CID_OP_INC_IR, `CID_OP_EI,
            `CID_OP_IDLE:    c = `CID_CYC_SHORT;
            `CID_OP_DI:      c = `CID_CYC_SHORT;
            `CID_OP_CP_RIR, `CID_OP_CP_RGRG, `CID_OP_CP_RGIR,
            `CID_OP_CP_IM:   c = `CID_CYC_LONG;
            default:         c = (o[3:0] == `CID_OP_INC_WR) ? `CID_CYC_SHORT : 3'h0;
        endcase
        return c;
    endfunction

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstn = rstPipe[1];

    // Fields of the latched instruction
    assign op = s.cmd[7:0];
    assign b1 = s.cmd[15:8];
    assign b2 = s.cmd[23:16];

    // Operand addressing per opcode form
    always_comb begin
        dstA   = idx(b1);
        srcVal = 8'h00;
        aluOp  = CID_ALU_NONE;
        unique case (op)
            `CID_OP_CP_RR: begin
                dstA   = idx({4'h0, b1[7:4]});
                srcVal = s.regs[idx({4'h0, b1[3:0]})];
                aluOp  = CID_ALU_CMP;
            end
            `CID_OP_CP_RIR: begin
                dstA   = idx({4'h0, b1[7:4]});
                srcVal = s.regs[idx(s.regs[idx({4'h0, b1[3:0]})])];
                aluOp  = CID_ALU_CMP;
            end
            `CID_OP_CP_RGRG: begin
                dstA   = idx(b2);
                srcVal = s.regs[idx(b1)];
                aluOp  = CID_ALU_CMP;
            end
            `CID_OP_CP_RGIR: begin
                dstA   = idx(b2);
                srcVal = s.regs[idx(s.regs[idx(b1)])];
                aluOp  = CID_ALU_CMP;
            end
            `CID_OP_CP_IM: begin
                dstA   = idx(b1);
                srcVal = b2;
                aluOp  = CID_ALU_CMP;
            end
            `CID_OP_DEC_R: begin
                aluOp = CID_ALU_DEC;
            end
            `CID_OP_DEC_IR: begin
                dstA  = idx(s.regs[idx(b1)]);
                aluOp = CID_ALU_DEC;
            end
            `CID_OP_INC_R: begin
                aluOp = CID_ALU_INC;
            end
            `CID_OP_INC_IR: begin
                dstA  = idx(s.regs[idx(b1)]);
                aluOp = CID_ALU_INC;
            end
            default: begin
                if (op[3:0] == `CID_OP_INC_WR) begin
                    dstA  = idx({4'h0, op[7:4]});
                    aluOp = CID_ALU_INC;
                end
            end
        endcase
        dstVal = s.regs[dstA];
    end

    // Flag and result unit
    cid_alu u_alu (
        .aluOp    (aluOp),
        .dstVal   (dstVal),
        .srcVal   (srcVal),
        .flagsIn  (s.flags),
        .result   (aluRes),
        .flagsOut (aluFlags)
    );

    // Bus decode helpers
    assign access  = psel && penable;
    assign regOff  = paddr - `CID_OFS_REGS;
    assign isReg   = (paddr >= `CID_OFS_REGS) && (regOff[1:0] == 2'h0)
                     && (regOff[11:2] < 10'(NREG));
    assign regIdx  = regOff[AW+1:2];
    assign irqEdge = s.irqSync & ~s.irqLast;

    // Next state of the whole block
    always_comb begin
        next_s = s;

        // Request pins synchronised, then edge found
        next_s.irqMeta = irqReq;
        next_s.irqSync = s.irqMeta;
        next_s.irqLast = s.irqSync;

        // APB answer one cycle into the access phase
        next_s.pready  = 1'b0;
        next_s.pslverr = 1'b0;
        next_s.prdata  = 32'h0000_0000;
        if (access && !s.pready) begin
            next_s.pready = 1'b1;
            if (paddr == `CID_OFS_CMD) begin
                // Refused write answers with zero data
                next_s.pslverr = pwrite && (s.st != CID_READY);
                next_s.prdata  = next_s.pslverr ? 32'h0000_0000 : {8'h00, s.cmd};
            end else if (paddr == `CID_OFS_STATUS) begin
                next_s.prdata[`CID_ST_BUSY_BIT]  = (s.st == CID_RUN);
                next_s.prdata[`CID_ST_SLEEP_BIT] = (s.st == CID_SLEEP);
                next_s.prdata[`CID_ST_BADOP_BIT] = s.badOp;
            end else if (paddr == `CID_OFS_FLAGS) begin
                next_s.prdata[7:0] = s.flags;
            end else if (paddr == `CID_OFS_SYSMODE) begin
                next_s.prdata[7:0] = s.system_mode_reg;
            end else if (paddr == `CID_OFS_PEND) begin
                next_s.prdata[NIRQ-1:0] = s.pend;
            end else if (isReg) begin
                next_s.prdata[7:0] = s.regs[regIdx];
            end else begin
                next_s.pslverr = 1'b1;
            end
        end

        // Writes take effect at the completing edge
        if (access && s.pready && pwrite && !s.pslverr) begin
            if (paddr == `CID_OFS_CMD) begin
                next_s.cmd = pwdata[23:0];
                if (cyclesOf(pwdata[7:0]) == 3'h0) begin
                    next_s.badOp = 1'b1;
                end else begin
                    next_s.badOp   = 1'b0;
                    next_s.st      = CID_RUN;
                    next_s.cycLeft = cyclesOf(pwdata[7:0]) - 3'h1;
                end
            end else if (paddr == `CID_OFS_FLAGS) begin
                next_s.flags = pwdata[7:0];
            end else if (paddr == `CID_OFS_SYSMODE) begin
                next_s.system_mode_reg = pwdata[7:0];
            end else if (isReg) begin
                next_s.regs[regIdx] = pwdata[7:0];
            end
        end

        next_s.pend = s.pend | irqEdge;
        if (access && s.pready && pwrite && !s.pslverr && paddr == `CID_OFS_PEND) begin
            // Write one to clear, a new request wins
            next_s.pend = (s.pend & ~pwdata[NIRQ-1:0]) | irqEdge;
        end

        // Instruction sequencing
        unique case (s.st)
            CID_READY: begin
            end
            CID_RUN: begin
                next_s.cycLeft = s.cycLeft - 3'h1;
                if (s.cycLeft == 3'h0) begin
                    next_s.st = CID_READY;
                    unique case (aluOp)
                        CID_ALU_CMP: begin
                            next_s.flags = aluFlags;
                        end
                        CID_ALU_DEC: begin
                            next_s.regs[dstA] = aluRes;
                            next_s.flags      = aluFlags;
                        end
                        CID_ALU_INC: begin
                            next_s.regs[dstA] = aluRes;
                            next_s.flags      = aluFlags;
                        end
                        CID_ALU_NONE: begin
                            if (op == `CID_OP_DI) begin
                                next_s.system_mode_reg[`CID_SYM_IE_BIT] = 1'b0;
                            end else if (op == `CID_OP_EI) begin
                                next_s.system_mode_reg[`CID_SYM_IE_BIT] = 1'b1;
                            end else if (op == `CID_OP_IDLE) begin
                                next_s.st = CID_SLEEP;
                            end
                        end
                    endcase
                end
            end
            CID_SLEEP: begin
                if (|irqEdge) begin
                    next_s.st = CID_READY;
                end
            end
        endcase

        // CPU clock gate, oscillator domain keeps running
        next_s.cpuClkEn = (next_s.st != CID_SLEEP);
        next_s.serviceReq = next_s.system_mode_reg[`CID_SYM_IE_BIT] && (|next_s.pend);
    end

    // State register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s            <= '0;
            s.st         <= CID_READY;
            s.flags      <= `CID_RST_FLAGS;
            s.system_mode_reg        <= `CID_RST_SYM;
            s.cpuClkEn   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign prdata     = s.prdata;
    assign pready     = s.pready;
    assign pslverr    = s.pslverr;
    assign cpuClkEn   = s.cpuClkEn;
    assign serviceReq = s.serviceReq;
endmodule
`default_nettype wire

// ==== hw/cid_params.svh ====
// Purpose: Constants for the compare/inc/dec/interrupt/idle execution block
// Assumes: APB byte addresses, 8-bit CPU data
// Notes:   Offsets, field positions, reset values, opcodes and cycle counts
`ifndef CID_PARAMS_SVH
`define CID_PARAMS_SVH

// Register byte offsets
`define CID_OFS_CMD     12'h000
`define CID_OFS_STATUS  12'h004
`define CID_OFS_FLAGS   12'h008
`define CID_OFS_SYSMODE 12'h00C
`define CID_OFS_PEND    12'h010
`define CID_OFS_REGS    12'h040

// Status fields
`define CID_ST_BUSY_BIT  0
`define CID_ST_SLEEP_BIT 1
`define CID_ST_BADOP_BIT 2

// Flags register fields
`define CID_FLAG_C 7
`define CID_FLAG_Z 6
`define CID_FLAG_S 5
`define CID_FLAG_V 4
`define CID_FLAG_D 3
`define CID_FLAG_H 2

// Global interrupt enable bit of system_mode_reg
`define CID_SYM_IE_BIT 2

// Reset values
`define CID_RST_FLAGS 8'h00
`define CID_RST_SYM   8'h00

// Opcodes
`define CID_OP_CP_RR   8'hA2
`define CID_OP_CP_RIR  8'hA3
`define CID_OP_CP_RGRG 8'hA4
`define CID_OP_CP_RGIR 8'hA5
`define CID_OP_CP_IM   8'hA6
`define CID_OP_DEC_R   8'h00
`define CID_OP_DEC_IR  8'h01
`define CID_OP_INC_R   8'h20
`define CID_OP_INC_IR  8'h21
`define CID_OP_INC_WR  4'hE
`define CID_OP_DI      8'h8F
`define CID_OP_EI      8'h9F
`define CID_OP_IDLE    8'h6F

// Overflow corner values
`define CID_MIN_NEG 8'h80
`define CID_MAX_POS 8'h7F

// Execution lengths in CPU cycles
`define CID_CYC_SHORT 3'h4
`define CID_CYC_LONG  3'h6

`endif

// ==== hw/cid_pkg.sv ====
// Purpose: Types shared by the execution block and its flag unit
// Assumes: Constants come from cid_params.svh
// Notes:   No codes given to states
package cid_pkg;
    typedef enum logic [1:0] {CID_READY, CID_RUN, CID_SLEEP} cid_state_t;
    typedef enum logic [1:0] {CID_ALU_NONE, CID_ALU_CMP, CID_ALU_DEC, CID_ALU_INC} cid_alu_op_t;
endpackage

// ==== hw/cid_alu.sv ====
// Purpose: Result and flag computation for compare, decrement, increment
// Assumes: 8-bit two's complement operands
// Notes:   Purely combinational; D and H pass through untouched
`include "cid_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cid_alu (
    // Operation select
    input  wire cid_pkg::cid_alu_op_t aluOp,
    // Operands and flags in
    input  wire logic [7:0]           dstVal,
    input  wire logic [7:0]           srcVal,
    input  wire logic [7:0]           flagsIn,
    // Results
    output logic [7:0]                result,
    output logic [7:0]                flagsOut
);
    import cid_pkg::*;

    // Result and flags per operation
    always_comb begin
        result   = dstVal;
        flagsOut = flagsIn;
        unique case (aluOp)
            CID_ALU_CMP: begin
                result = dstVal - srcVal;
                flagsOut[`CID_FLAG_C] = (srcVal > dstVal);
                flagsOut[`CID_FLAG_S] = result[7];
                flagsOut[`CID_FLAG_Z] = (result == 8'h00);
                flagsOut[`CID_FLAG_V] = (dstVal[7] != srcVal[7]) && (result[7] == srcVal[7]);
            end
            CID_ALU_DEC: begin
                result = dstVal - 8'h01;
                flagsOut[`CID_FLAG_Z] = (result == 8'h00);
                flagsOut[`CID_FLAG_S] = result[7];
                flagsOut[`CID_FLAG_V] = (dstVal == `CID_MIN_NEG) && (result == `CID_MAX_POS);
            end
            CID_ALU_INC: begin
                result = dstVal + 8'h01;
                flagsOut[`CID_FLAG_Z] = (result == 8'h00);
                flagsOut[`CID_FLAG_S] = result[7];
                flagsOut[`CID_FLAG_V] = (dstVal == `CID_MAX_POS) && (result == `CID_MIN_NEG);
            end
            CID_ALU_NONE: begin
                result   = dstVal;
                flagsOut = flagsIn;
            end
        endcase
    end
endmodule
`default_nettype wire

// ==== test/cid_exec_chk.sv ====
// Purpose: Port-level checks for the execution block
// Assumes: Sees only the cid_exec ports
// Notes:   Bound from the testbench top file
`include "cid_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cid_exec_chk #(
    parameter int NIRQ = 8
) (
    // Clock and reset
    input wire logic            ref_clk,
    input wire logic            resetn,
    // APB
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [11:0]     paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    // Requests and CPU side
    input wire logic [NIRQ-1:0] irqReq,
    input wire logic            cpuClkEn,
    input wire logic            serviceReq
);
    logic cmdTake;

    // Accepted command write
    assign cmdTake = psel && penable && pready && pwrite && !pslverr && (paddr == `CID_OFS_CMD);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // Bus answer timing and shape
    chk_ready_second: assert property (psel && penable && $past(psel && !penable)
        |-> !pready ##1 pready) else $error("pready not in second access cycle");
    chk_pready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside answer");
    chk_err_paired: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("pslverr without pready or with data");
    // Interrupt disable stops service
    chk_di_blocks: assert property (cmdTake && pwdata[7:0] == `CID_OP_DI |-> ##6 !serviceReq)
        else $error("service still requested after disable");
    // Disable acts four cycles after the command
    chk_di_timing: assert property (cmdTake && pwdata[7:0] == `CID_OP_DI && serviceReq
        |=> serviceReq [*4] ##1 !serviceReq) else $error("disable not effective after four cycles");
    // Idle gates CPU clock
    chk_idle_clk_off: assert property (
        (cmdTake && pwdata[7:0] == `CID_OP_IDLE && irqReq == '0)
        ##1 (irqReq == '0) [*5] |-> !cpuClkEn) else $error("CPU clock still on in idle");
    chk_stay_asleep: assert property ((!cpuClkEn && irqReq == '0) [*6] |=> !cpuClkEn)
        else $error("idle left without request");
    // Request wakes from idle
    chk_wake_irq: assert property (!cpuClkEn && (irqReq & ~$past(irqReq)) != '0
        |-> ##[1:8] cpuClkEn) else $error("idle not left on request");

    // Main scenarios reached
    cov_idle: cover property ($fell(cpuClkEn));
    cov_service: cover property ($rose(serviceReq));
    cov_refused: cover property (pslverr);
    cov_cmd: cover property (cmdTake);
endmodule
`default_nettype wire

// ==== test/cpu_cmp_incdec_int_idle_exec_tb.sv ====
// Purpose: Self-checking bench for the execution block
// Assumes: Bench is APB master and drives irqReq directly
// Notes:   Reset values first, then table rows, then hand-written cases
`include "cid_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cpu_cmp_incdec_int_idle_exec_tb;
    import cid_pkg::*;
    typedef struct packed {
        logic [31:0] cmd;
        logic [7:0]  dst;
        logic [7:0]  src;
        logic [7:0]  flg;
        logic [7:0]  expDst;
        logic [7:0]  expFlg;
    } cid_row_t;
    localparam logic [11:0] ADDR_R5 = `CID_OFS_REGS + 12'h014;
    localparam logic [11:0] ADDR_R6 = `CID_OFS_REGS + 12'h018;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  irqReq = 8'h00;
    logic        cpuClkEn;
    logic        serviceReq;
    logic [31:0] rdVal;
    logic        errVal;
    int          err_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [11:0] rstAddr [5] = '{`CID_OFS_FLAGS, `CID_OFS_SYSMODE, `CID_OFS_PEND,
                                 `CID_OFS_STATUS, `CID_OFS_REGS};
    // Command, dst r5, src r6, flags in, expected r5 and flags
    cid_row_t    rows [11] = '{
        '{32'h0000_56A2, 8'h02, 8'h03, 8'h0C, 8'h02, 8'hAC},
        '{32'h0000_57A3, 8'h05, 8'h05, 8'hFC, 8'h05, 8'h4C},
        '{32'h0005_06A4, 8'h80, 8'h01, 8'h00, 8'h80, 8'h10},
        '{32'h0005_07A5, 8'h01, 8'h80, 8'h00, 8'h01, 8'hB0},
        '{32'h0040_05A6, 8'h40, 8'h40, 8'h80, 8'h40, 8'h40},
        '{32'h0000_0500, 8'h80, 8'h00, 8'h8C, 8'h7F, 8'h9C},
        '{32'h0000_0801, 8'h01, 8'h00, 8'h00, 8'h00, 8'h40},
        '{32'h0000_0500, 8'h00, 8'h00, 8'h10, 8'hFF, 8'h20},
        '{32'h0000_0520, 8'h7F, 8'h00, 8'h8C, 8'h80, 8'hBC},
        '{32'h0000_0821, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h40},
        '{32'h0000_005E, 8'h10, 8'h00, 8'h70, 8'h11, 8'h00}};

    cid_exec dut (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .irqReq     (irqReq),
        .cpuClkEn   (cpuClkEn),
        .serviceReq (serviceReq)
    );

    // Clock
    always #2 ref_clk = ~ref_clk;

    // Cycle ceiling against hangs
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            stop_test();
        end
    end

    // Counts and verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rdVal = prdata;
        errVal = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // Poll until the command finishes
    task automatic waitIdle();
        rd(`CID_OFS_STATUS);
        while (rdVal[`CID_ST_BUSY_BIT] !== 1'b0) begin
            rd(`CID_OFS_STATUS);
        end
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(32'(cpuClkEn), 32'h0000_0001);
        foreach (rstAddr[i]) begin
            rd(rstAddr[i]);
            check(rdVal, 32'h0000_0000);
        end
        $display("reset values done");
        wr(`CID_OFS_REGS + 12'h01C, 32'h0000_0006);
        wr(`CID_OFS_REGS + 12'h020, 32'h0000_0005);
        foreach (rows[i]) begin
            wr(ADDR_R5, {24'h00_0000, rows[i].dst});
            wr(ADDR_R6, {24'h00_0000, rows[i].src});
            wr(`CID_OFS_FLAGS, {24'h00_0000, rows[i].flg});
            wr(`CID_OFS_CMD, rows[i].cmd);
            waitIdle();
            rd(ADDR_R5);
            check(rdVal, {24'h00_0000, rows[i].expDst});
            rd(ADDR_R6);
            check(rdVal, {24'h00_0000, rows[i].src});
            rd(`CID_OFS_FLAGS);
            check(rdVal, {24'h00_0000, rows[i].expFlg});
            $display("row %0d done", i);
        end
        rd(12'h020);
        check({rdVal[30:0], errVal}, 32'h0000_0001);
        // Disable keeps other mode bits, requests still pend
        wr(`CID_OFS_SYSMODE, 32'h0000_00FF);
        irqReq <= 8'h01;
        repeat (6) @(posedge ref_clk);
        check(32'(serviceReq), 32'h0000_0001);
        wr(`CID_OFS_CMD, {24'h00_0000, `CID_OP_DI});
        waitIdle();
        rd(`CID_OFS_SYSMODE);
        check(rdVal, 32'h0000_00FB);
        check(32'(serviceReq), 32'h0000_0000);
        irqReq <= 8'h09;
        repeat (6) @(posedge ref_clk);
        irqReq <= 8'h00;
        rd(`CID_OFS_PEND);
        check(rdVal, 32'h0000_0009);
        check(32'(serviceReq), 32'h0000_0000);
        wr(`CID_OFS_CMD, {24'h00_0000, `CID_OP_EI});
        waitIdle();
        rd(`CID_OFS_SYSMODE);
        check(rdVal, 32'h0000_00FF);
        check(32'(serviceReq), 32'h0000_0001);
        wr(`CID_OFS_PEND, 32'h0000_0009);
        rd(`CID_OFS_PEND);
        check(rdVal | 32'(serviceReq), 32'h0000_0000);
        $display("interrupt test done");
        // Command refused while busy, unknown opcode flagged
        wr(`CID_OFS_CMD, 32'h0005_06A4);
        wr(`CID_OFS_CMD, 32'h0000_009F);
        check(32'(errVal), 32'h0000_0001);
        rd(`CID_OFS_CMD);
        check(rdVal, 32'h0005_06A4);
        waitIdle();
        wr(`CID_OFS_CMD, 32'h0000_00FF);
        waitIdle();
        check(32'(rdVal[`CID_ST_BADOP_BIT]), 32'h0000_0001);
        $display("refusal test done");
        // Idle, left by a request
        wr(`CID_OFS_CMD, {24'h00_0000, `CID_OP_IDLE});
        repeat (8) @(posedge ref_clk);
        check(32'(cpuClkEn), 32'h0000_0000);
        rd(`CID_OFS_STATUS);
        check(32'(rdVal[`CID_ST_SLEEP_BIT]), 32'h0000_0001);
        wr(`CID_OFS_CMD, 32'h0000_0520);
        check(32'(errVal), 32'h0000_0001);
        irqReq <= 8'h02;
        for (int k = 0; k < 12 && cpuClkEn !== 1'b1; k++) @(posedge ref_clk);
        check(32'(cpuClkEn), 32'h0000_0001);
        irqReq <= 8'h00;
        wr(`CID_OFS_PEND, 32'h0000_00FF);
        // Idle, left by reset
        wr(`CID_OFS_CMD, {24'h00_0000, `CID_OP_IDLE});
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(32'(cpuClkEn), 32'h0000_0001);
        rd(`CID_OFS_FLAGS);
        check(rdVal, 32'h0000_0000);
        $display("idle test done");
        stop_test();
    end
endmodule

bind cid_exec cid_exec_chk #(.NIRQ(NIRQ)) u_chk (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .irqReq     (irqReq),
    .cpuClkEn   (cpuClkEn),
    .serviceReq (serviceReq)
);
`default_nettype wire
